// file: logic/rci_pkg.sv
// constants and types for the reset-cause and register-initialisation block
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
`default_nettype none
package rci_pkg;
    localparam int RCI_PC_W = 21;
    localparam logic [RCI_PC_W-1:0] RCI_PC_RESET   = 21'h000000;
    localparam logic [RCI_PC_W-1:0] RCI_VEC_HIGH   = 21'h000008;
    localparam logic [RCI_PC_W-1:0] RCI_VEC_LOW    = 21'h000018;
    localparam logic [RCI_PC_W-1:0] RCI_PC_STEP    = 21'h000002;

    // register offsets
    localparam logic [7:0] RCI_OFS_CAUSE   = 8'h00;
    localparam logic [7:0] RCI_OFS_STACK_POINTER_REG  = 8'h01;
    localparam logic [7:0] RCI_OFS_TOPU    = 8'h02;
    localparam logic [7:0] RCI_OFS_TOPH    = 8'h03;
    localparam logic [7:0] RCI_OFS_TOPL    = 8'h04;
    localparam logic [7:0] RCI_OFS_PC_LATCH_UPPER  = 8'h05;
    localparam logic [7:0] RCI_OFS_PC_LATCH_HIGH  = 8'h06;
    localparam logic [7:0] RCI_OFS_PCL     = 8'h07;
    localparam logic [7:0] RCI_OFS_TBLU    = 8'h08;
    localparam logic [7:0] RCI_OFS_TBLH    = 8'h09;
    localparam logic [7:0] RCI_OFS_TBLL    = 8'h0a;
    localparam logic [7:0] RCI_OFS_TABLE_LATCH  = 8'h0b;
    localparam logic [7:0] RCI_OFS_INTC1   = 8'h0c;
    localparam logic [7:0] RCI_OFS_INTC2   = 8'h0d;
    localparam logic [7:0] RCI_OFS_INTC3   = 8'h0e;
    localparam logic [7:0] RCI_OFS_SCRATCH = 8'h0f;
    localparam logic [7:0] RCI_OFS_LASTEVT = 8'h10;

    // reset_cause_reg field positions
    localparam int RCI_BIT_IPEN   = 7;
    localparam int RCI_BIT_SOFT_BROWNOUT_ENABLE = 6;
    localparam int RCI_BIT_RI     = 4;
    localparam int RCI_BIT_TO     = 3;
    localparam int RCI_BIT_PD     = 2;
    localparam int RCI_BIT_POR    = 1;
    localparam int RCI_BIT_BOR    = 0;
    localparam logic [7:0] RCI_CAUSE_MASK = 8'hdf;
    localparam logic [7:0] RCI_CAUSE_SWWR = 8'hd3;
    localparam logic [7:0] RCI_CAUSE_POR  = 8'h5c;

    // stack_pointer_reg field positions
    localparam int RCI_BIT_STKFULL = 7;
    localparam int RCI_BIT_STACK_UNDERFLOW_FLAG  = 6;
    localparam logic [7:0] RCI_STK_FLAGS = 8'hc0;
    localparam logic [7:0] RCI_STK_MASK  = 8'hdf;

    // interrupt control reset patterns and implemented bits
    localparam logic [7:0] RCI_INTC1_RST  = 8'h00;
    localparam logic [7:0] RCI_INTC1_KEEP = 8'h01;
    localparam logic [7:0] RCI_INTC2_RST  = 8'hf5;
    localparam logic [7:0] RCI_INTC2_MASK = 8'hf5;
    localparam logic [7:0] RCI_INTC3_RST  = 8'hc0;
    localparam logic [7:0] RCI_INTC3_MASK = 8'hdb;
    localparam int RCI_BIT_HIGH_PRIO_INT_GLOBAL_ENABLE = 7;
    localparam int RCI_BIT_LOW_PRIO_INT_GLOBAL_ENABLE = 6;

    localparam logic [1:0] RCI_BORMODE_SOFT = 2'b01;

    typedef enum logic [1:0] {
        RCI_PM_FULL  = 2'b00,
        RCI_PM_RUN   = 2'b01,
        RCI_PM_IDLE  = 2'b10,
        RCI_PM_SLEEP = 2'b11
    } rci_pmode_t;

    typedef enum logic [3:0] {
        RCI_EV_NONE     = 4'b0000,
        RCI_EV_POR      = 4'b0001,
        RCI_EV_BOR      = 4'b0010,
        RCI_EV_MASTER_CLEAR_PIN     = 4'b0011,
        RCI_EV_WDT_RST  = 4'b0100,
        RCI_EV_WDT_WAKE = 4'b0101,
        RCI_EV_STK_OVF  = 4'b0110,
        RCI_EV_STK_UNF  = 4'b0111,
        RCI_EV_UNF_ERR  = 4'b1000,
        RCI_EV_RST_INS  = 4'b1001,
        RCI_EV_INT_WAKE = 4'b1010,
        RCI_EV_OVF_ERR  = 4'b1011
    } rci_evt_t;

    typedef struct packed {
        logic power_on;
        logic brown_out;
        logic master_clear;
        logic watchdog;
        logic reset_instr;
        logic stack_overflow;
        logic stack_underflow;
        logic int_wake;
    } rci_events_t;

    typedef struct packed {
        logic [7:0]          cause;
        logic [7:0]          stack_pointer_reg;
        logic [4:0]          topu;
        logic [7:0]          toph;
        logic [7:0]          topl;
        logic [4:0]          pc_latch_upper;
        logic [7:0]          pc_latch_high;
        logic [7:0]          pc_low_byte;
        logic [5:0]          tblu;
        logic [7:0]          tblh;
        logic [7:0]          tbll;
        logic [7:0]          table_latch;
        logic [7:0]          intc1;
        logic [7:0]          intc2;
        logic [7:0]          intc3;
        logic [7:0]          scratch;
        logic [7:0]          rdata;
        rci_evt_t            last_evt;
        logic                core_rst;
        logic                pc_load;
        logic [RCI_PC_W-1:0] pc_val;
        logic                bor_en;
    } rci_state_t;
endpackage
`default_nettype wire

// file: logic/rci_reset_init.sv
// reset-cause recording and special-register initialisation
`timescale 1ns/10ps
`default_nettype none
module rci_reset_init
    import rci_pkg::*;
(
    input  wire logic                CLK_SYS_I,
    input  wire logic                RST_I,
    input  wire rci_events_t         RST_EVT_I,
    input  wire rci_pmode_t          PWR_MODE_I,
    input  wire logic [1:0]          BROWNOUT_MODE_SELECT_I,
    input  wire logic                STACK_FAULT_RESET_ENABLE_I,
    input  wire logic                INT_HIGH_PRIO_I,
    input  wire logic [RCI_PC_W-1:0] PC_I,
    input  wire logic [7:0]          REG_ADDR_I,
    input  wire logic [7:0]          REG_WDATA_I,
    input  wire logic                REG_WR_I,
    input  wire logic                REG_RD_I,
    output logic [7:0]               REG_RDATA_O,
    output logic                     CORE_RESET_O,
    output logic                     PC_LOAD_O,
    output logic [RCI_PC_W-1:0]      PC_VALUE_O,
    output logic                     BROWNOUT_EN_O
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // severity order decides which flags a clash of sources leaves behind
    function automatic rci_evt_t classify(input rci_events_t e, input rci_pmode_t m, input logic stv);
        logic asleep;
        asleep = (m == RCI_PM_IDLE) || (m == RCI_PM_SLEEP);
        if (e.power_on)                       classify = RCI_EV_POR;
        else if (e.brown_out)                 classify = RCI_EV_BOR;
        else if (e.master_clear)              classify = RCI_EV_MASTER_CLEAR_PIN;
        else if (e.watchdog && asleep)        classify = RCI_EV_WDT_WAKE;
        else if (e.watchdog)                  classify = RCI_EV_WDT_RST;
        else if (e.stack_overflow && stv)     classify = RCI_EV_STK_OVF;
        else if (e.stack_underflow && stv)    classify = RCI_EV_STK_UNF;
        else if (e.stack_underflow)           classify = RCI_EV_UNF_ERR;
        else if (e.stack_overflow)            classify = RCI_EV_OVF_ERR;
        else if (e.reset_instr)               classify = RCI_EV_RST_INS;
        else if (e.int_wake && m != RCI_PM_FULL) classify = RCI_EV_INT_WAKE;
        else                                  classify = RCI_EV_NONE;
    endfunction

    // reset-class initial values; the power-on class also clears the stack flags
    function automatic rci_state_t init_regs(input rci_state_t s, input logic full);
        rci_state_t r;
        r        = s;
        r.topu   = 5'h00;
        r.toph   = 8'h00;
        r.topl   = 8'h00;
        r.pc_latch_upper = 5'h00;
        r.pc_latch_high = 8'h00;
        r.pc_low_byte    = 8'h00;
        r.tblu   = 6'h00;
        r.tblh   = 8'h00;
        r.tbll   = 8'h00;
        r.table_latch = 8'h00;
        r.stack_pointer_reg = full ? 8'h00 : (s.stack_pointer_reg & RCI_STK_FLAGS);
        r.intc1  = RCI_INTC1_RST | (full ? 8'h00 : (s.intc1 & RCI_INTC1_KEEP));
        r.intc2  = RCI_INTC2_RST;
        r.intc3  = RCI_INTC3_RST;
        r.cause[RCI_BIT_IPEN] = 1'b0;
        init_regs = r;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    rci_state_t st_r;
    rci_state_t st_nxt;
    rci_evt_t   evt;
    logic       soft_mode;
    logic [RCI_PC_W-1:0] pc_plus2;

    assign soft_mode = (BROWNOUT_MODE_SELECT_I == RCI_BORMODE_SOFT);
    assign pc_plus2  = PC_I + RCI_PC_STEP;
    assign evt       = classify(RST_EVT_I, PWR_MODE_I, STACK_FAULT_RESET_ENABLE_I);

    always_comb begin
        st_nxt          = st_r;
        st_nxt.core_rst = 1'b0;
        st_nxt.pc_load  = 1'b0;
        st_nxt.rdata    = 8'h00;

        // ---- register read, answered next cycle ----
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                RCI_OFS_CAUSE: begin
                    st_nxt.rdata = st_r.cause & RCI_CAUSE_MASK;
                    st_nxt.rdata[RCI_BIT_SOFT_BROWNOUT_ENABLE] = st_r.cause[RCI_BIT_SOFT_BROWNOUT_ENABLE] & soft_mode;
                end
                RCI_OFS_STACK_POINTER_REG:  st_nxt.rdata = st_r.stack_pointer_reg & RCI_STK_MASK;
                RCI_OFS_TOPU:    st_nxt.rdata = {3'h0, st_r.topu};
                RCI_OFS_TOPH:    st_nxt.rdata = st_r.toph;
                RCI_OFS_TOPL:    st_nxt.rdata = st_r.topl;
                RCI_OFS_PC_LATCH_UPPER:  st_nxt.rdata = {3'h0, st_r.pc_latch_upper};
                RCI_OFS_PC_LATCH_HIGH:  st_nxt.rdata = st_r.pc_latch_high;
                RCI_OFS_PCL:     st_nxt.rdata = st_r.pc_low_byte;
                RCI_OFS_TBLU:    st_nxt.rdata = {2'h0, st_r.tblu};
                RCI_OFS_TBLH:    st_nxt.rdata = st_r.tblh;
                RCI_OFS_TBLL:    st_nxt.rdata = st_r.tbll;
                RCI_OFS_TABLE_LATCH:  st_nxt.rdata = st_r.table_latch;
                RCI_OFS_INTC1:   st_nxt.rdata = st_r.intc1;
                RCI_OFS_INTC2:   st_nxt.rdata = st_r.intc2 & RCI_INTC2_MASK;
                RCI_OFS_INTC3:   st_nxt.rdata = st_r.intc3 & RCI_INTC3_MASK;
                RCI_OFS_SCRATCH: st_nxt.rdata = st_r.scratch;
                RCI_OFS_LASTEVT: st_nxt.rdata = {4'h0, st_r.last_evt};
                default:         st_nxt.rdata = 8'h00;
            endcase
        end

        // ---- register write; hardware events below override it ----
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                // timeout and powerdown are hardware-owned, so software cannot fake a timeout or powerdown
                RCI_OFS_CAUSE:   st_nxt.cause = (st_r.cause & ~RCI_CAUSE_SWWR) | (REG_WDATA_I & RCI_CAUSE_SWWR);
                RCI_OFS_STACK_POINTER_REG:  st_nxt.stack_pointer_reg = REG_WDATA_I & RCI_STK_MASK;
                RCI_OFS_TOPU:    st_nxt.topu = REG_WDATA_I[4:0];
                RCI_OFS_TOPH:    st_nxt.toph = REG_WDATA_I;
                RCI_OFS_TOPL:    st_nxt.topl = REG_WDATA_I;
                RCI_OFS_PC_LATCH_UPPER:  st_nxt.pc_latch_upper = REG_WDATA_I[4:0];
                RCI_OFS_PC_LATCH_HIGH:  st_nxt.pc_latch_high = REG_WDATA_I;
                RCI_OFS_PCL:     st_nxt.pc_low_byte = REG_WDATA_I;
                RCI_OFS_TBLU:    st_nxt.tblu = REG_WDATA_I[5:0];
                RCI_OFS_TBLH:    st_nxt.tblh = REG_WDATA_I;
                RCI_OFS_TBLL:    st_nxt.tbll = REG_WDATA_I;
                RCI_OFS_TABLE_LATCH:  st_nxt.table_latch = REG_WDATA_I;
                RCI_OFS_INTC1:   st_nxt.intc1 = REG_WDATA_I;
                RCI_OFS_INTC2:   st_nxt.intc2 = REG_WDATA_I & RCI_INTC2_MASK;
                RCI_OFS_INTC3:   st_nxt.intc3 = REG_WDATA_I & RCI_INTC3_MASK;
                RCI_OFS_SCRATCH: st_nxt.scratch = REG_WDATA_I;
                default: ;
            endcase
        end

        // ---- reset and wake-up events ----
        if (evt != RCI_EV_NONE) begin
            st_nxt.last_evt = evt;
        end
        case (evt)
            RCI_EV_POR: begin
                // scratch is left alone: its power-on value is simply whatever it holds
                st_nxt = init_regs(st_nxt, 1'b1);
                st_nxt.cause[RCI_BIT_SOFT_BROWNOUT_ENABLE] = 1'b1;
                st_nxt.cause[RCI_BIT_RI]  = 1'b1;
                st_nxt.cause[RCI_BIT_TO]  = 1'b1;
                st_nxt.cause[RCI_BIT_PD]  = 1'b1;
                st_nxt.cause[RCI_BIT_POR] = 1'b0;
                st_nxt.cause[RCI_BIT_BOR] = 1'b0;
                st_nxt.core_rst = 1'b1;
                st_nxt.pc_load  = 1'b1;
                st_nxt.pc_val   = RCI_PC_RESET;
            end
            RCI_EV_BOR: begin
                st_nxt = init_regs(st_nxt, 1'b0);
                st_nxt.cause[RCI_BIT_SOFT_BROWNOUT_ENABLE] = soft_mode & st_r.cause[RCI_BIT_SOFT_BROWNOUT_ENABLE];
                st_nxt.cause[RCI_BIT_RI]  = 1'b1;
                st_nxt.cause[RCI_BIT_TO]  = 1'b1;
                st_nxt.cause[RCI_BIT_PD]  = 1'b1;
                st_nxt.cause[RCI_BIT_BOR] = 1'b0;
                st_nxt.core_rst = 1'b1;
                st_nxt.pc_load  = 1'b1;
                st_nxt.pc_val   = RCI_PC_RESET;
            end
            RCI_EV_MASTER_CLEAR_PIN, RCI_EV_WDT_RST, RCI_EV_STK_OVF, RCI_EV_STK_UNF, RCI_EV_RST_INS: begin
                st_nxt = init_regs(st_nxt, 1'b0);
                st_nxt.cause[RCI_BIT_SOFT_BROWNOUT_ENABLE] = soft_mode & st_r.cause[RCI_BIT_SOFT_BROWNOUT_ENABLE];
                st_nxt.core_rst = 1'b1;
                st_nxt.pc_load  = 1'b1;
                st_nxt.pc_val   = RCI_PC_RESET;
                if (evt == RCI_EV_MASTER_CLEAR_PIN && PWR_MODE_I != RCI_PM_FULL) begin
                    st_nxt.cause[RCI_BIT_TO] = 1'b1;
                    if (PWR_MODE_I != RCI_PM_RUN) begin
                        st_nxt.cause[RCI_BIT_PD] = 1'b0;
                    end
                end
                // full-power master clear touches no flag
                if (evt == RCI_EV_WDT_RST) st_nxt.cause[RCI_BIT_TO] = 1'b0;
                if (evt == RCI_EV_STK_OVF) st_nxt.stack_pointer_reg[RCI_BIT_STKFULL] = 1'b1;
                if (evt == RCI_EV_STK_UNF) st_nxt.stack_pointer_reg[RCI_BIT_STACK_UNDERFLOW_FLAG] = 1'b1;
                if (evt == RCI_EV_RST_INS) st_nxt.cause[RCI_BIT_RI] = 1'b0;
            end
            RCI_EV_UNF_ERR: begin
                // no reset: the core carries on, only the flag and a zero pc are reported
                st_nxt.stack_pointer_reg[RCI_BIT_STACK_UNDERFLOW_FLAG] = 1'b1;
                st_nxt.pc_load = 1'b1;
                st_nxt.pc_val  = RCI_PC_RESET;
            end
            RCI_EV_OVF_ERR: begin
                st_nxt.stack_pointer_reg[RCI_BIT_STKFULL] = 1'b1;
            end
            RCI_EV_WDT_WAKE: begin
                // watchdog wake: everything retained except the pc low byte and the timeout and powerdown flags
                st_nxt.cause[RCI_BIT_TO] = 1'b0;
                st_nxt.cause[RCI_BIT_PD] = 1'b0;
                st_nxt.pc_low_byte     = pc_plus2[7:0];
                st_nxt.pc_load = 1'b1;
                st_nxt.pc_val  = pc_plus2;
            end
            RCI_EV_INT_WAKE: begin
                st_nxt.cause[RCI_BIT_PD] = 1'b0;
                st_nxt.pc_load = 1'b1;
                if (st_r.intc1[RCI_BIT_HIGH_PRIO_INT_GLOBAL_ENABLE] || st_r.intc1[RCI_BIT_LOW_PRIO_INT_GLOBAL_ENABLE]) begin
                    st_nxt.pc_val = INT_HIGH_PRIO_I ? RCI_VEC_HIGH : RCI_VEC_LOW;
                end else begin
                    st_nxt.pc_val = pc_plus2;
                end
                st_nxt.pc_low_byte = st_nxt.pc_val[7:0];
            end
            default: ;
        endcase

        // detector enable follows the configured brown-out mode
        case (BROWNOUT_MODE_SELECT_I)
            2'b00:   st_nxt.bor_en = 1'b0;
            2'b01:   st_nxt.bor_en = st_nxt.cause[RCI_BIT_SOFT_BROWNOUT_ENABLE];
            2'b10:   st_nxt.bor_en = (PWR_MODE_I != RCI_PM_SLEEP);
            default: st_nxt.bor_en = 1'b1;
        endcase
    end

    // asynchronous reset is the power-on class of values
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            st_r          <= '0;
            st_r.cause    <= RCI_CAUSE_POR;
            st_r.intc2    <= RCI_INTC2_RST;
            st_r.intc3    <= RCI_INTC3_RST;
            st_r.last_evt <= RCI_EV_POR;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign REG_RDATA_O   = st_r.rdata;
    assign CORE_RESET_O  = st_r.core_rst;
    assign PC_LOAD_O     = st_r.pc_load;
    assign PC_VALUE_O    = st_r.pc_val;
    assign BROWNOUT_EN_O = st_r.bor_en;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    AST_POR_FLAGS: assert property (RST_EVT_I.power_on |=>
        CORE_RESET_O && PC_VALUE_O == RCI_PC_RESET && st_r.cause[4:0] == 5'b11100 && st_r.stack_pointer_reg == 8'h00)
        else $error("power-on flags wrong");
    AST_BOR_KEEP: assert property (!RST_EVT_I.power_on && RST_EVT_I.brown_out |=>
        st_r.cause[RCI_BIT_POR] == $past(st_r.cause[RCI_BIT_POR]) && st_r.cause[4:2] == 3'b111
        && !st_r.cause[RCI_BIT_BOR] && (st_r.stack_pointer_reg & RCI_STK_FLAGS) == ($past(st_r.stack_pointer_reg) & RCI_STK_FLAGS))
        else $error("brown-out flags wrong");
    AST_RESET_INSTR: assert property (evt == RCI_EV_RST_INS && !REG_WR_I |=>
        !st_r.cause[RCI_BIT_RI] && st_r.cause[3:0] == $past(st_r.cause[3:0]) && CORE_RESET_O)
        else $error("reset instruction flags wrong");
    AST_MASTER_CLEAR_PIN_IDLE: assert property (evt == RCI_EV_MASTER_CLEAR_PIN && PWR_MODE_I inside {RCI_PM_IDLE, RCI_PM_SLEEP} |=>
        st_r.cause[RCI_BIT_TO] && !st_r.cause[RCI_BIT_PD] && PC_VALUE_O == RCI_PC_RESET)
        else $error("master clear in idle wrong");
    AST_MASTER_CLEAR_PIN_FULL: assert property (evt == RCI_EV_MASTER_CLEAR_PIN && PWR_MODE_I == RCI_PM_FULL && !REG_WR_I |=>
        CORE_RESET_O && st_r.cause[4:0] == $past(st_r.cause[4:0]))
        else $error("full-power master clear changed flags");
    AST_WDT_RUN: assert property (evt == RCI_EV_WDT_RST |=>
        CORE_RESET_O && !st_r.cause[RCI_BIT_TO] && PC_VALUE_O == RCI_PC_RESET)
        else $error("watchdog reset wrong");
    AST_WDT_WAKE: assert property (evt == RCI_EV_WDT_WAKE |=>
        !CORE_RESET_O && PC_LOAD_O && PC_VALUE_O == $past(PC_I) + RCI_PC_STEP && st_r.cause[3:2] == 2'b00)
        else $error("watchdog wake wrong");
    AST_STK_OVF: assert property (evt == RCI_EV_STK_OVF |=>
        CORE_RESET_O && st_r.stack_pointer_reg[RCI_BIT_STKFULL] && st_r.stack_pointer_reg[4:0] == 5'h00)
        else $error("stack overflow reset wrong");
    AST_STK_UNF: assert property (evt == RCI_EV_STK_UNF |=> CORE_RESET_O && st_r.stack_pointer_reg[RCI_BIT_STACK_UNDERFLOW_FLAG])
        else $error("stack underflow reset wrong");
    AST_UNF_ERR: assert property (evt == RCI_EV_UNF_ERR |=>
        !CORE_RESET_O && PC_LOAD_O && PC_VALUE_O == RCI_PC_RESET && st_r.stack_pointer_reg[RCI_BIT_STACK_UNDERFLOW_FLAG])
        else $error("stack underflow error wrong");
    AST_INT_VEC: assert property (evt == RCI_EV_INT_WAKE && (st_r.intc1[7] || st_r.intc1[6]) |=>
        !CORE_RESET_O && !st_r.cause[RCI_BIT_PD] && PC_VALUE_O == ($past(INT_HIGH_PRIO_I) ? RCI_VEC_HIGH : RCI_VEC_LOW))
        else $error("interrupt wake vector wrong");
    AST_SOFT_BROWNOUT_ENABLE_READ: assert property (REG_RD_I && REG_ADDR_I == RCI_OFS_CAUSE && !soft_mode |=>
        !REG_RDATA_O[RCI_BIT_SOFT_BROWNOUT_ENABLE])
        else $error("soft brown-out enable visible outside soft mode");

    // ------------------------------------------------------------------
    // reset-class and wake-class checks
    // ------------------------------------------------------------------
    AST_INT_WAKE_PC: assert property (evt == RCI_EV_INT_WAKE && st_r.intc1[7:6] == 2'b00 && !REG_WR_I |=>
        !CORE_RESET_O && PC_LOAD_O && PC_VALUE_O == $past(PC_I) + RCI_PC_STEP && !st_r.cause[RCI_BIT_PD]
        && st_r.cause[4:3] == $past(st_r.cause[4:3]) && st_r.cause[1:0] == $past(st_r.cause[1:0]))
        else $error("interrupt wake without vector wrong");
    // an interrupt ignored in full power must not move the pc
    AST_NO_EVENT: assert property (evt == RCI_EV_NONE |=> !CORE_RESET_O && !PC_LOAD_O)
        else $error("pc loaded without an event");
    AST_WAKE_KEEP: assert property (evt inside {RCI_EV_WDT_WAKE, RCI_EV_INT_WAKE} && !REG_WR_I |=>
        st_r.stack_pointer_reg == $past(st_r.stack_pointer_reg) && st_r.intc1 == $past(st_r.intc1)
        && st_r.table_latch == $past(st_r.table_latch) && st_r.toph == $past(st_r.toph))
        else $error("wake-up disturbed retained registers");
    AST_WDT_WAKE_FLAGS: assert property (evt == RCI_EV_WDT_WAKE && !REG_WR_I |=>
        st_r.cause[4] == $past(st_r.cause[4]) && st_r.cause[1:0] == $past(st_r.cause[1:0]))
        else $error("watchdog wake touched other flags");
    AST_SCRATCH_KEEP: assert property (evt != RCI_EV_NONE && !REG_WR_I |=>
        st_r.scratch == $past(st_r.scratch))
        else $error("undefined-reset register disturbed");
    AST_BOR_RESTART: assert property (!RST_EVT_I.power_on && RST_EVT_I.brown_out |=>
        CORE_RESET_O && PC_LOAD_O && PC_VALUE_O == RCI_PC_RESET)
        else $error("brown-out restart wrong");
    AST_RESET_CLEARS: assert property (CORE_RESET_O |->
        st_r.pc_low_byte == 8'h00 && st_r.pc_latch_high == 8'h00 && st_r.toph == 8'h00 && st_r.tblh == 8'h00 && st_r.table_latch == 8'h00)
        else $error("reset left a cleared register set");
    AST_STK_PTR_CLR: assert property (CORE_RESET_O |-> st_r.stack_pointer_reg[4:0] == 5'h00)
        else $error("reset left the stack pointer field set");
    AST_INTC_PATTERN: assert property (CORE_RESET_O |->
        st_r.intc1[7:1] == 7'h00 && st_r.intc2 == RCI_INTC2_RST && st_r.intc3 == RCI_INTC3_RST)
        else $error("interrupt control reset pattern wrong");
    AST_SOFT_BROWNOUT_ENABLE_POR: assert property (RST_EVT_I.power_on |=> st_r.cause[RCI_BIT_SOFT_BROWNOUT_ENABLE])
        else $error("soft brown-out enable not set at power-on");
    AST_SOFT_BROWNOUT_ENABLE_KEEP: assert property (evt inside {RCI_EV_BOR, RCI_EV_MASTER_CLEAR_PIN, RCI_EV_WDT_RST, RCI_EV_STK_OVF,
        RCI_EV_STK_UNF, RCI_EV_RST_INS} |=>
        st_r.cause[RCI_BIT_SOFT_BROWNOUT_ENABLE] == ($past(soft_mode) && $past(st_r.cause[RCI_BIT_SOFT_BROWNOUT_ENABLE])))
        else $error("soft brown-out enable wrong after reset");
    AST_UNF_ERR_KEEP: assert property (evt == RCI_EV_UNF_ERR && !REG_WR_I |=>
        st_r.cause == $past(st_r.cause) && st_r.stack_pointer_reg[RCI_BIT_STKFULL] == $past(st_r.stack_pointer_reg[RCI_BIT_STKFULL]))
        else $error("stack underflow error touched other flags");
    AST_BOREN_SLEEP: assert property (BROWNOUT_MODE_SELECT_I == 2'b10 && PWR_MODE_I == RCI_PM_SLEEP |=>
        !BROWNOUT_EN_O)
        else $error("detector left on in sleep");
    AST_SEVERITY: assert property (RST_EVT_I.brown_out |->
        evt == (RST_EVT_I.power_on ? RCI_EV_POR : RCI_EV_BOR))
        else $error("reset sources ranked wrongly");
    AST_RDATA_IDLE: assert property (!REG_RD_I |=> REG_RDATA_O == 8'h00)
        else $error("read data outside the answer cycle");
    AST_WAKE_PCL: assert property (evt == RCI_EV_WDT_WAKE |=> st_r.pc_low_byte == PC_VALUE_O[7:0])
        else $error("pc low byte not advanced on wake");

    // ------------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------------

    COV_POR:      cover property (RST_EVT_I.power_on ##1 CORE_RESET_O);
    COV_WDT_WAKE: cover property (evt == RCI_EV_WDT_WAKE ##1 PC_LOAD_O);
    COV_INT_VEC:  cover property (evt == RCI_EV_INT_WAKE && st_r.intc1[7]);
    COV_CLASH:    cover property (RST_EVT_I.power_on && RST_EVT_I.brown_out);
    COV_UNF_ERR:  cover property (evt == RCI_EV_UNF_ERR ##1 PC_LOAD_O);
endmodule // rci_reset_init
`default_nettype wire

// file: testbench/rci_reset_init_tb_top.sv
// self-checking bench for the reset-cause and register-initialisation block
`timescale 1ns/10ps
`default_nettype none
module rci_reset_init_tb_top
    import rci_pkg::*;
();
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    rci_events_t   evt = '0;
    rci_pmode_t    md  = RCI_PM_FULL;
    logic [1:0]    bm  = 2'b01;
    logic          sf  = 1'b1;
    logic          hp  = 1'b0;
    logic [20:0]   pc  = 21'h000100;
    logic [7:0]    ad  = '0;
    logic [7:0]    wd  = '0;
    logic          wr  = 1'b0;
    logic          rd  = 1'b0;
    logic [7:0]    rdat;
    logic          crst;
    logic          ld;
    logic [20:0]   pv;
    logic          ben;
    int            mismatches = 0;
    int            comparisons = 0;
    always #50 clk = ~clk;
    rci_reset_init DUT (.CLK_SYS_I(clk), .RST_I(rst), .RST_EVT_I(evt), .PWR_MODE_I(md),
        .BROWNOUT_MODE_SELECT_I(bm), .STACK_FAULT_RESET_ENABLE_I(sf), .INT_HIGH_PRIO_I(hp),
        .PC_I(pc), .REG_ADDR_I(ad), .REG_WDATA_I(wd), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_RDATA_O(rdat), .CORE_RESET_O(crst), .PC_LOAD_O(ld), .PC_VALUE_O(pv),
        .BROWNOUT_EN_O(ben));
    task automatic chk(input logic [20:0] s, input logic [20:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        ad <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        ad <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdat, e);
    endtask
    task automatic ev(input logic [7:0] e, input rci_pmode_t m, input logic c, input logic [20:0] p,
                      input logic [7:0] cz);
        @(posedge clk);
        evt <= rci_events_t'(e);
        md <= m;
        @(posedge clk);
        evt <= '0;
        #1 chk(crst, c);
        chk(ld, 1'b1);
        chk(pv, p);
        rchk(RCI_OFS_CAUSE, cz);
    endtask
    // ------------------------------------------------------------------
    // event sequence; each cause value follows from the one before
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rchk(RCI_OFS_CAUSE, 8'h5c);
        rchk(RCI_OFS_INTC2, 8'hf5);
        rchk(RCI_OFS_INTC3, 8'hc0);
        rchk(8'h20, 8'h00);
        chk(ben, 1'b1);
        wreg(RCI_OFS_CAUSE, 8'h53);
        wreg(RCI_OFS_SCRATCH, 8'ha5);
        rchk(RCI_OFS_CAUSE, 8'h5f);
        ev(8'h08, RCI_PM_FULL, 1, 0, 8'h4f);
        ev(8'h10, RCI_PM_RUN, 1, 0, 8'h47);
        ev(8'h20, RCI_PM_RUN, 1, 0, 8'h4f);
        ev(8'h10, RCI_PM_FULL, 1, 0, 8'h47);
        ev(8'h20, RCI_PM_IDLE, 1, 0, 8'h4b);
        ev(8'h20, RCI_PM_FULL, 1, 0, 8'h4b);
        ev(8'h10, RCI_PM_SLEEP, 0, 21'h102, 8'h43);
        ev(8'h40, RCI_PM_FULL, 1, 0, 8'h5e);
        ev(8'h01, RCI_PM_IDLE, 0, 21'h102, 8'h5a);
        wreg(RCI_OFS_INTC1, 8'h80);
        hp <= 1'b1;
        ev(8'h01, RCI_PM_SLEEP, 0, 21'h008, 8'h5a);
        hp <= 1'b0;
        ev(8'h01, RCI_PM_SLEEP, 0, 21'h018, 8'h5a);
        rchk(RCI_OFS_PCL, 8'h18);
        ev(8'h04, RCI_PM_FULL, 1, 0, 8'h5a);
        rchk(RCI_OFS_STACK_POINTER_REG, 8'h80);
        rchk(RCI_OFS_PCL, 8'h00);
        wreg(RCI_OFS_STACK_POINTER_REG, 8'h85);
        ev(8'h02, RCI_PM_FULL, 1, 0, 8'h5a);
        ev(8'h20, RCI_PM_FULL, 1, 0, 8'h5a);
        rchk(RCI_OFS_STACK_POINTER_REG, 8'hc0);
        rchk(RCI_OFS_SCRATCH, 8'ha5);
        wreg(RCI_OFS_STACK_POINTER_REG, 8'h00);
        @(posedge clk);
        sf <= 1'b0;
        evt <= rci_events_t'(8'h02);
        @(posedge clk);
        evt <= '0;
        #1 chk(crst, 1'b0);
        chk(ld, 1'b1);
        chk(pv, 21'h0);
        rchk(RCI_OFS_STACK_POINTER_REG, 8'h40);
        wreg(RCI_OFS_CAUSE, 8'h13);
        rchk(RCI_OFS_CAUSE, 8'h1b);
        chk(ben, 1'b0);
        @(posedge clk);
        bm <= 2'b11;
        wreg(RCI_OFS_CAUSE, 8'h53);
        rchk(RCI_OFS_CAUSE, 8'h1b);
        chk(ben, 1'b1);
        @(posedge clk);
        bm <= 2'b10;
        md <= RCI_PM_SLEEP;
        @(posedge clk);
        @(posedge clk);
        #1 chk(ben, 1'b0);
        @(posedge clk);
        bm <= 2'b01;
        ev(8'hf1, RCI_PM_IDLE, 1, 0, 8'h5c);
        rchk(RCI_OFS_STACK_POINTER_REG, 8'h00);
        give_verdict();
    end
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
endmodule // rci_reset_init_tb_top
`default_nettype wire
